//--- hdl/mid_cfg_if.sv
// Purpose: carries configuration updates to the holding registers
// Assumes: single clock
// Notes: ctl drives update strobes, regs returns the held values
`timescale 1ns/1ps
interface mid_cfg_if;
  logic siWr;
  logic [7:0] siD;
  logic ckWr;
  logic [3:0] ckD;
  logic carWr;
  logic [1:0] carD;
  logic bankWr;
  logic bankD;
  logic [7:0] si;
  logic [3:0] ck;
  logic [1:0] car;
  logic bank;

  modport ctl (
    output siWr, siD, ckWr, ckD, carWr, carD, bankWr, bankD,
    input si, ck, car, bank
  );
  modport regs (
    input siWr, siD, ckWr, ckD, carWr, carD, bankWr, bankD,
    output si, ck, car, bank
  );
endinterface : mid_cfg_if

//--- hdl/mid_cfgregs.sv
// Purpose: holds scratch, clock control, carrier control and bank bit
// Assumes: at most one update per field per cycle, merged upstream
// Notes: all values are flip-flop outputs
`timescale 1ns/1ps
module mid_cfgregs (
  input wire logic clk,
  input wire logic rst,
  mid_cfg_if.regs cfg
);
`include "mid_regs.svh"

  logic [7:0] si_q, si_d;
  logic [3:0] ck_q, ck_d;
  logic [1:0] car_q, car_d;
  logic bank_q, bank_d;

  always_comb begin
    si_d = cfg.siWr ? cfg.siD : si_q;
    ck_d = cfg.ckWr ? cfg.ckD : ck_q;
    car_d = cfg.carWr ? cfg.carD : car_q;
    bank_d = cfg.bankWr ? cfg.bankD : bank_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      si_q <= `MID_RST_SCRATCH;
      ck_q <= `MID_RST_CLKCTL;
      car_q <= `MID_RST_CARRIER;
      bank_q <= `MID_RST_BANK;
    end else begin
      si_q <= si_d;
      ck_q <= ck_d;
      car_q <= car_d;
      bank_q <= bank_d;
    end
  end

  assign cfg.si = si_q;
  assign cfg.ck = ck_q;
  assign cfg.car = car_q;
  assign cfg.bank = bank_q;

endmodule : mid_cfgregs

//--- hdl/mid_decoder.sv
// Purpose: decodes and executes carrier, power, watchdog, scratch,
//   clock-control and bank instructions of a 4-bit core
// Assumes: one instruction word per cycle when instrValid is high;
//   register port per plain address/strobe protocol
// Notes: accumulator results leave one cycle after the instruction
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module mid_decoder
  import mid_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire mid_pkg::mid_word_t instrWord,
  input wire mid_pkg::mid_nib_t accA,
  input wire mid_pkg::mid_nib_t accB,
  input wire logic powerdownFlag,
  input wire logic wdTimeoutEvt,
  input wire logic [5:0] tablePageLow,
  output logic pcAdvance,
  output logic accWr,
  output mid_pkg::mid_nib_t accANew,
  output mid_pkg::mid_nib_t accBNew,
  output logic skipNext,
  output logic backupEnter,
  output logic wdRestart,
  output logic [1:0] carrierCtl,
  output mid_pkg::mid_nib_t clockCtl,
  output logic [6:0] tablePage,
  output logic watchdogTimeoutFlag,
  output logic watchdogEnableFlag,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData
);
  import mid_pkg::*;
`include "mid_regs.svh"

  // ==================================================================
  // helpers
  function automatic logic [7:0] pack_ab(input logic [3:0] hi,
                                         input logic [3:0] lo);
    pack_ab = {hi, lo};
  endfunction : pack_ab

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction : hit

  // ==================================================================
  // decode
  mid_op_e op;
  logic exec;
  mid_arm_e arm_q, arm_d;
  logic skipPend_q, skipPend_d;
  logic backup_q, backup_d;

  // a word that arrives while a skip is pending is consumed, not run
  assign exec = instrValid && !skipPend_q;

  mid_opdec u_opdec (
    .valid(exec),
    .word(instrWord),
    .op(op)
  );

  mid_cfg_if cfg ();

  mid_cfgregs u_cfgregs (
    .clk(clk),
    .rst(rst),
    .cfg(cfg)
  );

  // ==================================================================
  // sequencing state: arming and skip
  always_comb begin
    arm_d = arm_q;
    skipPend_d = skipPend_q;
    backup_d = 1'b0;
    if (instrValid) begin
      // any word, skipped or run, ends a pending skip
      skipPend_d = 1'b0;
      case (arm_q)
        MID_ARM_IDLE: begin
          if (op == MID_OP_ARM) begin
            arm_d = MID_ARM_READY;
          end
        end
        MID_ARM_READY: begin
          // arming covers only the very next word
          arm_d = (op == MID_OP_ARM) ? MID_ARM_READY : MID_ARM_IDLE;
          if (op == MID_OP_POFF) begin
            backup_d = 1'b1;
          end
        end
        default: arm_d = MID_ARM_IDLE;
      endcase
      // flag is only sampled here, never written back
      if (op == MID_OP_PDSKIP && powerdownFlag) begin
        skipPend_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arm_q <= MID_ARM_IDLE;
      skipPend_q <= 1'b0;
      backup_q <= 1'b0;
    end else begin
      arm_q <= arm_d;
      skipPend_q <= skipPend_d;
      backup_q <= backup_d;
    end
  end

  assign skipNext = skipPend_q;
  assign backupEnter = backup_q;

  // every word of this group is one word: advance by one
  assign pcAdvance = instrValid;

  // ==================================================================
  // accumulator results
  logic accWr_q, accWr_d;
  logic [3:0] accA_q, accA_d;
  logic [3:0] accB_q, accB_d;

  always_comb begin
    accWr_d = 1'b0;
    accA_d = accA_q;
    accB_d = accB_q;
    case (op)
      MID_OP_SIREAD: begin
        accWr_d = 1'b1;
        accB_d = cfg.si[7:4];
        accA_d = cfg.si[3:0];
      end
      MID_OP_CKREAD: begin
        accWr_d = 1'b1;
        accA_d = cfg.ck;
        accB_d = accB;
      end
      default: begin
        accWr_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      accWr_q <= 1'b0;
      accA_q <= 4'h0;
      accB_q <= 4'h0;
    end else begin
      accWr_q <= accWr_d;
      accA_q <= accA_d;
      accB_q <= accB_d;
    end
  end

  assign accWr = accWr_q;
  assign accANew = accA_q;
  assign accBNew = accB_q;

  // ==================================================================
  // watchdog flags
  logic wdf_q, wdf_d;
  logic wef_q, wef_d;
  logic wdRst_q, wdRst_d;
  logic swWr;

  assign swWr = regWr && hit(regAddr, `MID_REG_STATUS);

  always_comb begin
    wdf_d = wdf_q;
    wef_d = wef_q;
    wdRst_d = 1'b0;
    // software may clear the enable flag through the status register
    if (swWr && !regWrData[`MID_ST_WEF]) begin
      wef_d = 1'b0;
    end
    if (swWr && regWrData[`MID_ST_WDF]) begin
      wdf_d = 1'b0;
    end
    if (op == MID_OP_WDRST) begin
      wdf_d = 1'b0;
      wef_d = 1'b1;
      wdRst_d = 1'b1;
    end
    // a timeout in the cycle of a clear is kept
    if (wdTimeoutEvt) begin
      wdf_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wdf_q <= `MID_RST_WDF;
      wef_q <= `MID_RST_WEF;
      wdRst_q <= 1'b0;
    end else begin
      wdf_q <= wdf_d;
      wef_q <= wef_d;
      wdRst_q <= wdRst_d;
    end
  end

  assign watchdogTimeoutFlag = wdf_q;
  assign watchdogEnableFlag = wef_q;
  assign wdRestart = wdRst_q;

  // ==================================================================
  // configuration updates; an instruction beats software in one cycle
  always_comb begin
    cfg.siWr = 1'b0;
    cfg.siD = cfg.si;
    cfg.ckWr = 1'b0;
    cfg.ckD = cfg.ck;
    cfg.carWr = 1'b0;
    cfg.carD = cfg.car;
    cfg.bankWr = 1'b0;
    cfg.bankD = cfg.bank;
    if (regWr) begin
      case (regAddr)
        `MID_REG_SCRATCH: begin
          cfg.siWr = 1'b1;
          cfg.siD = regWrData;
        end
        `MID_REG_CLKCTL: begin
          cfg.ckWr = 1'b1;
          cfg.ckD = regWrData[3:0];
        end
        `MID_REG_CARRIER: begin
          cfg.carWr = 1'b1;
          cfg.carD = regWrData[1:0];
        end
        `MID_REG_BANK: begin
          cfg.bankWr = 1'b1;
          cfg.bankD = regWrData[0];
        end
        default: begin
          cfg.siWr = 1'b0;
        end
      endcase
    end
    case (op)
      MID_OP_CARLOAD: begin
        cfg.carWr = 1'b1;
        cfg.carD = accA[1:0];
      end
      MID_OP_SIWRITE: begin
        cfg.siWr = 1'b1;
        cfg.siD = pack_ab(accB, accA);
      end
      MID_OP_CKWRITE: begin
        cfg.ckWr = 1'b1;
        cfg.ckD = accA;
      end
      MID_OP_BKSET: begin
        cfg.bankWr = 1'b1;
        cfg.bankD = 1'b1;
      end
      MID_OP_BKCLR: begin
        cfg.bankWr = 1'b1;
        cfg.bankD = 1'b0;
      end
      default: begin
        cfg.bankWr = cfg.bankWr;
      end
    endcase
  end

  assign carrierCtl = cfg.car;
  assign clockCtl = cfg.ck;

  // the bank bit reaches the paged table reference and the register read port
  assign tablePage = {cfg.bank, tablePageLow};

  // ==================================================================
  // register read port, data one cycle after the strobe
  logic [7:0] rd_q, rd_d;
  logic [7:0] status;

  always_comb begin
    status = 8'h00;
    status[`MID_ST_BANK] = cfg.bank;
    status[`MID_ST_ARMED] = (arm_q == MID_ARM_READY);
    status[`MID_ST_SKIP] = skipPend_q;
    status[`MID_ST_PDFLAG] = powerdownFlag;
    status[`MID_ST_WDF] = wdf_q;
    status[`MID_ST_WEF] = wef_q;
    rd_d = 8'h00;
    if (regRd) begin
      case (regAddr)
        `MID_REG_STATUS: rd_d = status;
        `MID_REG_SCRATCH: rd_d = cfg.si;
        `MID_REG_CLKCTL: rd_d = {4'h0, cfg.ck};
        `MID_REG_CARRIER: rd_d = {6'h00, cfg.car};
        `MID_REG_BANK: rd_d = {7'h00, cfg.bank};
        default: rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign regRdData = rd_q;

endmodule : mid_decoder

//--- hdl/mid_opdec.sv
// Purpose: classifies one program word into a decoded operation
// Assumes: word is only meaningful while valid is high
// Notes: purely combinational
`timescale 1ns/1ps
module mid_opdec
  import mid_pkg::*;
(
  input wire logic valid,
  input wire mid_pkg::mid_word_t word,
  output mid_pkg::mid_op_e op
);
`include "mid_regs.svh"

  always_comb begin
    op = MID_OP_NONE;
    if (valid) begin
      case (word)
        `MID_OP_CARRIER_LOAD: op = MID_OP_CARLOAD;
        `MID_OP_NOP: op = MID_OP_NOP;
        `MID_OP_POWER_OFF: op = MID_OP_POFF;
        `MID_OP_POWER_OFF_ARM: op = MID_OP_ARM;
        `MID_OP_PD_SKIP: op = MID_OP_PDSKIP;
        `MID_OP_WD_RESTART: op = MID_OP_WDRST;
        `MID_OP_SCRATCH_READ: op = MID_OP_SIREAD;
        `MID_OP_SCRATCH_WRITE: op = MID_OP_SIWRITE;
        `MID_OP_CLKCTL_READ: op = MID_OP_CKREAD;
        `MID_OP_CLKCTL_WRITE: op = MID_OP_CKWRITE;
        `MID_OP_BANK_SET: op = MID_OP_BKSET;
        `MID_OP_BANK_CLEAR: op = MID_OP_BKCLR;
        default: op = MID_OP_NONE;
      endcase
    end
  end

endmodule : mid_opdec

//--- hdl/mid_pkg.sv
// Purpose: shared types of the miscellaneous instruction decoder
// Assumes: nothing
// Notes: op codes are one-hot so each decode term is one bit
package mid_pkg;

  // ==================================================================
  // decoded operation
  typedef enum logic [12:0] {
    MID_OP_NONE     = 13'h0001,
    MID_OP_CARLOAD  = 13'h0002,
    MID_OP_NOP      = 13'h0004,
    MID_OP_POFF     = 13'h0008,
    MID_OP_ARM      = 13'h0010,
    MID_OP_PDSKIP   = 13'h0020,
    MID_OP_WDRST    = 13'h0040,
    MID_OP_SIREAD   = 13'h0080,
    MID_OP_SIWRITE  = 13'h0100,
    MID_OP_CKREAD   = 13'h0200,
    MID_OP_CKWRITE  = 13'h0400,
    MID_OP_BKSET    = 13'h0800,
    MID_OP_BKCLR    = 13'h1000
  } mid_op_e;

  // ==================================================================
  // power-off arming sequence
  typedef enum logic [1:0] {
    MID_ARM_IDLE  = 2'b01,
    MID_ARM_READY = 2'b10
  } mid_arm_e;

  typedef logic [3:0] mid_nib_t;
  typedef logic [9:0] mid_word_t;

endpackage : mid_pkg

//--- hdl/mid_regs.svh
// Purpose: constants of the miscellaneous instruction decoder
// Assumes: included by bare name from design files
// Notes: register offsets index the plain register port
`ifndef MID_REGS_SVH
`define MID_REGS_SVH

// ====================================================================
// opcodes, one 10-bit program word each
`define MID_OP_CARRIER_LOAD 10'h2A9
`define MID_OP_NOP 10'h000
`define MID_OP_POWER_OFF 10'h002
`define MID_OP_POWER_OFF_ARM 10'h05B
`define MID_OP_PD_SKIP 10'h003
`define MID_OP_WD_RESTART 10'h2A0
`define MID_OP_SCRATCH_READ 10'h278
`define MID_OP_SCRATCH_WRITE 10'h238
`define MID_OP_CLKCTL_READ 10'h252
`define MID_OP_CLKCTL_WRITE 10'h216
`define MID_OP_BANK_SET 10'h041
`define MID_OP_BANK_CLEAR 10'h040

// ====================================================================
// register offsets
`define MID_REG_STATUS 4'h0
`define MID_REG_SCRATCH 4'h1
`define MID_REG_CLKCTL 4'h2
`define MID_REG_CARRIER 4'h3
`define MID_REG_BANK 4'h4

// ====================================================================
// status field positions
`define MID_ST_BANK 0
`define MID_ST_ARMED 1
`define MID_ST_SKIP 2
`define MID_ST_PDFLAG 3
`define MID_ST_WDF 4
`define MID_ST_WEF 5

// ====================================================================
// reset values
`define MID_RST_SCRATCH 8'h00
`define MID_RST_CLKCTL 4'h0
`define MID_RST_CARRIER 2'h0
`define MID_RST_BANK 1'b0
`define MID_RST_WDF 1'b0
`define MID_RST_WEF 1'b0

`endif

//--- test/mid_decoder_props.sv
// Purpose: port-level checks of the instruction decoder
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every decoder instance
`timescale 1ns/1ps
`include "mid_regs.svh"
module mid_decoder_props
  import mid_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire mid_pkg::mid_word_t instrWord,
  input wire mid_pkg::mid_nib_t accA,
  input wire mid_pkg::mid_nib_t accB,
  input wire logic powerdownFlag,
  input wire logic wdTimeoutEvt,
  input wire logic [5:0] tablePageLow,
  input wire logic regWr,
  input wire logic pcAdvance,
  input wire logic accWr,
  input wire mid_pkg::mid_nib_t accANew,
  input wire mid_pkg::mid_nib_t accBNew,
  input wire logic skipNext,
  input wire logic backupEnter,
  input wire logic wdRestart,
  input wire logic [1:0] carrierCtl,
  input wire mid_pkg::mid_nib_t clockCtl,
  input wire logic [6:0] tablePage,
  input wire logic watchdogTimeoutFlag,
  input wire logic watchdogEnableFlag
);
  // ==================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  logic offTaken;
  // a word arriving while a skip is pending never counts as executed
  assign take = instrValid && !skipNext;
  assign offTaken = take && instrWord == `MID_OP_POWER_OFF;
  carrier_load_a: assert property (
    take && instrWord == `MID_OP_CARRIER_LOAD |=>
    carrierCtl == $past(accA[1:0]))
    else $error("carrier control not loaded");
  nop_quiet_a: assert property (
    take && instrWord == `MID_OP_NOP && !regWr |=> !accWr && !wdRestart
    && !skipNext && $stable(carrierCtl) && $stable(clockCtl))
    else $error("no-op changed state");
  armed_off_a: assert property (
    take && instrWord == `MID_OP_POWER_OFF_ARM ##1 offTaken |=> backupEnter)
    else $error("armed power-off ignored");
  backup_cause_a: assert property (
    backupEnter |-> $past(offTaken))
    else $error("back-up entry without power-off");
  unarmed_off_a: assert property (
    take && instrWord != `MID_OP_POWER_OFF_ARM ##1 offTaken |=> !backupEnter)
    else $error("unarmed power-off acted");
  skip_set_a: assert property (
    take && instrWord == `MID_OP_PD_SKIP |=> skipNext == $past(powerdownFlag))
    else $error("skip decision wrong");
  skip_consume_a: assert property (
    skipNext && instrValid |=> !skipNext && !accWr && !wdRestart)
    else $error("skipped word acted");
  wd_restart_a: assert property (
    take && instrWord == `MID_OP_WD_RESTART && !wdTimeoutEvt |=>
    wdRestart && !watchdogTimeoutFlag && watchdogEnableFlag)
    else $error("watchdog restart wrong");
  scratch_pair_a: assert property (
    take && instrWord == `MID_OP_SCRATCH_WRITE ##1
    take && instrWord == `MID_OP_SCRATCH_READ |=>
    accWr && {accBNew, accANew} == {$past(accB, 2), $past(accA, 2)})
    else $error("scratch round trip wrong");
  clk_write_a: assert property (
    take && instrWord == `MID_OP_CLKCTL_WRITE |=> clockCtl == $past(accA))
    else $error("clock control not written");
  bank_bit_a: assert property (
    take && (instrWord == `MID_OP_BANK_SET || instrWord == `MID_OP_BANK_CLEAR)
    |=> tablePage[6] == $past(instrWord[0]))
    else $error("bank bit wrong");
  page_low_a: assert property (
    tablePage[5:0] == tablePageLow && pcAdvance == instrValid)
    else $error("page or program counter step wrong");
  cover property (offTaken ##1 backupEnter);
  cover property (skipNext && instrValid);
  cover property (accWr);
endmodule : mid_decoder_props

bind mid_decoder mid_decoder_props u_props (.clk, .rst, .instrValid,
  .instrWord, .accA, .accB, .powerdownFlag, .wdTimeoutEvt, .tablePageLow,
  .regWr, .pcAdvance, .accWr, .accANew, .accBNew, .skipNext, .backupEnter,
  .wdRestart, .carrierCtl, .clockCtl, .tablePage, .watchdogTimeoutFlag,
  .watchdogEnableFlag);

//--- test/testbench.sv
// Purpose: random and corner tests of the instruction decoder
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes: expectations come from a small state model kept here
`timescale 1ns/1ps
`include "mid_regs.svh"
module testbench;
  import mid_pkg::*;
  `define CK(g, e) begin nCompared++; if ((g) !== (e)) begin failCount++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
  logic clk, rst, instrValid, powerdownFlag, wdTimeoutEvt, regWr, regRd;
  mid_word_t instrWord;
  mid_nib_t accA, accB, accANew, accBNew, clockCtl;
  logic [5:0] tablePageLow;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, rd, si;
  logic pcAdvance, accWr, skipNext, backupEnter, wdRestart;
  logic watchdogTimeoutFlag, watchdogEnableFlag;
  logic [1:0] carrierCtl, car;
  logic [6:0] tablePage;
  logic [3:0] ck;
  logic bank, armed, skipP, wdf, watchdog_enable_flag;
  logic [31:0] seed = 32'hDF12;
  int failCount, nCompared, cycles;
  mid_word_t ops[13] = '{`MID_OP_CARRIER_LOAD, `MID_OP_NOP,
    `MID_OP_POWER_OFF, `MID_OP_POWER_OFF_ARM, `MID_OP_PD_SKIP,
    `MID_OP_WD_RESTART, `MID_OP_SCRATCH_READ, `MID_OP_SCRATCH_WRITE,
    `MID_OP_CLKCTL_READ, `MID_OP_CLKCTL_WRITE, `MID_OP_BANK_SET,
    `MID_OP_BANK_CLEAR, 10'h3FF};

  mid_decoder DUT (.clk, .rst, .instrValid, .instrWord, .accA, .accB,
    .powerdownFlag, .wdTimeoutEvt, .tablePageLow, .pcAdvance, .accWr,
    .accANew, .accBNew, .skipNext, .backupEnter, .wdRestart, .carrierCtl,
    .clockCtl, .tablePage, .watchdogTimeoutFlag, .watchdogEnableFlag,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData);

  // ==================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic conclude;
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic reg_io(input logic wr, input logic [3:0] a,
      input logic [7:0] d);
    @(posedge clk);
    regWr <= wr;
    regRd <= !wr;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1 rd = regRdData;
  endtask : reg_io

  // two words on consecutive edges, then results of the second
  task automatic pair(input mid_word_t w1, input mid_word_t w2,
      input logic [9:0] e);
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= w1;
    accA <= 4'hA;
    accB <= 4'h5;
    @(posedge clk);
    instrWord <= w2;
    @(posedge clk);
    instrValid <= 1'b0;
    #1 `CK({backupEnter, accWr, accWr ? {accBNew, accANew} : 8'h00}, e)
  endtask : pair

  task automatic step(input mid_word_t w);
    logic [3:0] e;
    logic [14:0] g, x;
    logic pd, evt, ex;
    seed = lfsr(seed);
    pd = seed[8];
    evt = seed[9] & seed[10];
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= w;
    accA <= seed[3:0];
    accB <= seed[7:4];
    powerdownFlag <= pd;
    wdTimeoutEvt <= evt;
    tablePageLow <= seed[16:11];
    @(posedge clk);
    instrValid <= 1'b0;
    wdTimeoutEvt <= 1'b0;
    #1;
    ex = !skipP;
    e = {ex && (w == `MID_OP_SCRATCH_READ || w == `MID_OP_CLKCTL_READ),
      ex && w == `MID_OP_POWER_OFF && armed, ex && w == `MID_OP_WD_RESTART,
      ex && w == `MID_OP_PD_SKIP && pd};
    `CK({accWr, backupEnter, wdRestart, skipNext}, e)
    if (ex && w == `MID_OP_SCRATCH_READ) `CK({accBNew, accANew}, si)
    if (ex && w == `MID_OP_CLKCTL_READ)
      `CK({accBNew, accANew}, {seed[7:4], ck})
    armed = ex && w == `MID_OP_POWER_OFF_ARM;
    skipP = ex && w == `MID_OP_PD_SKIP && pd;
    if (ex && w == `MID_OP_CARRIER_LOAD) car = seed[1:0];
    if (ex && w == `MID_OP_SCRATCH_WRITE) si = seed[7:0];
    if (ex && w == `MID_OP_CLKCTL_WRITE) ck = seed[3:0];
    if (ex && w[9:1] == 9'h020) bank = w[0];
    if (evt) wdf = 1'b1;
    else if (ex && w == `MID_OP_WD_RESTART) wdf = 1'b0;
    if (ex && w == `MID_OP_WD_RESTART) watchdog_enable_flag = 1'b1;
    g = {carrierCtl, clockCtl, tablePage, watchdogTimeoutFlag,
      watchdogEnableFlag};
    x = {car, ck, bank, seed[16:11], wdf, watchdog_enable_flag};
    `CK(g, x)
    reg_io(1'b0, `MID_REG_STATUS, 8'h00);
    `CK(rd, {2'b00, watchdog_enable_flag, wdf, pd, skipP, armed, bank})
    reg_io(1'b0, `MID_REG_SCRATCH, 8'h00);
    `CK(rd, si)
  endtask : step

  // ==================================================================
  // main sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      failCount++;
      conclude();
    end
  end

  initial begin
    {rst, instrValid, powerdownFlag, wdTimeoutEvt, regWr, regRd} = 6'h20;
    {instrWord, accA, accB, tablePageLow, regAddr, regWrData} = '0;
    {si, car, ck, bank, armed, skipP, wdf, watchdog_enable_flag} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      reg_io(1'b0, i == 5 ? 4'hF : 4'(i), 8'h00);
      `CK(rd, 8'h00)
    end
    $display("test reset done");
    reg_io(1'b1, `MID_REG_SCRATCH, 8'hC3);
    reg_io(1'b1, 4'hF, 8'hFF);
    reg_io(1'b0, `MID_REG_SCRATCH, 8'h00);
    `CK(rd, 8'hC3)
    reg_io(1'b1, `MID_REG_CLKCTL, 8'hF7);
    reg_io(1'b1, `MID_REG_CARRIER, 8'hFE);
    reg_io(1'b1, `MID_REG_BANK, 8'hFF);
    reg_io(1'b0, `MID_REG_CLKCTL, 8'h00);
    `CK({rd, clockCtl}, {8'h07, 4'h7})
    reg_io(1'b0, `MID_REG_CARRIER, 8'h00);
    `CK({rd, carrierCtl}, {8'h02, 2'h2})
    reg_io(1'b0, `MID_REG_BANK, 8'h00);
    `CK({rd, tablePage[6]}, {8'h01, 1'b1})
    reg_io(1'b1, `MID_REG_BANK, 8'h00);
    car = 2'h2;
    $display("test registers done");
    pair(`MID_OP_SCRATCH_WRITE, `MID_OP_SCRATCH_READ, 10'h15A);
    pair(`MID_OP_CLKCTL_WRITE, `MID_OP_CLKCTL_READ, 10'h15A);
    pair(`MID_OP_POWER_OFF_ARM, `MID_OP_POWER_OFF, 10'h200);
    pair(`MID_OP_NOP, `MID_OP_POWER_OFF, 10'h000);
    si = 8'h5A;
    ck = 4'hA;
    $display("test back-to-back done");
    for (int i = 0; i < 200; i++) step(i < 13 ? ops[i] : ops[seed % 13]);
    $display("test random done");
    // bit 4 set clears the timeout flag, bit 5 clear drops the enable flag
    reg_io(1'b1, `MID_REG_STATUS, 8'h10);
    reg_io(1'b0, `MID_REG_STATUS, 8'h00);
    `CK({rd[5:4], watchdogTimeoutFlag, watchdogEnableFlag}, 4'h0)
    $display("test status clear done");
    conclude();
  end
endmodule : testbench
